// [psm_status_top.sv]
// Status indicators, strap capture and 10/100 media mode selection with APB registers
//
// The address map and register access over APB were chosen for this implementation.
`timescale 1ns/1ns
`include "psm_defs.svh"


module psm_status_top (
   input  wire logic                   sys_clk,
   input  wire logic                   rstn,
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [`PSM_ADDR_W-1:0] paddr,
   input  wire logic [31:0]            pwdata,
   input  wire logic [3:0]             pstrb,
   output logic      [31:0]            prdata,
   output logic                        pready,
   output logic                        pslverr,
   input  wire logic                   linkOkIn,
   input  wire logic                   txActiveIn,
   input  wire logic                   rxActiveIn,
   input  wire logic                   collisionIn,
   input  wire logic                   anCompleteIn,
   input  wire logic                   anSpeed100In,
   input  wire logic                   anFullDuplexIn,
   input  wire logic [`PSM_PIN_COUNT-1:0] dualPinIn,
   output logic      [`PSM_PIN_COUNT-1:0] dualPinOut,
   output logic      [`PSM_PIN_COUNT-1:0] dualPinOeN,
   output logic      [`PSM_PIN_COUNT-1:0] addressStrap,
   output logic                        speedIndicator,
   output logic                        lineDriverPairMode100,
   output logic                        receiverMode100
);

   // ****************************************************************
   // Declarations
   // ****************************************************************
   logic [`PSM_CTRL_W-1:0]    ctrl_reg;
   logic [`PSM_EV_W-1:0]      event_reg;
   logic [`PSM_EV_W-1:0]      eventSet;
   logic [`PSM_EV_W-1:0]      eventClr;
   logic [31:0]               prdata_reg;
   logic                      strapDone_reg;
   logic                      linkPrev_reg;
   logic                      speed100_reg;
   logic                      speed100_next;
   logic                      fullDuplex_reg;
   logic                      fullDuplex_next;
   psm_pkg::psm_mode_t        modeState_reg;
   psm_pkg::psm_mode_t        modeState_next;
   logic [`PSM_PIN_COUNT-1:0] levelNext;
   logic                      anEnable;
   logic                      forceSpeed100;
   logic                      forceFullDuplex;
   logic                      colLevel;
   logic                      addrHit;
   logic                      setupPhase;
   logic                      accessPhase;
   logic                      wrAccess;

   assign anEnable        = ctrl_reg[`PSM_CTRL_AN_EN_BIT];
   assign forceSpeed100   = ctrl_reg[`PSM_CTRL_SPD100_BIT];
   assign forceFullDuplex = ctrl_reg[`PSM_CTRL_FULLDUP_BIT];

   // ****************************************************************
   // APB slave
   // ****************************************************************
   // Zero wait states: read data is fetched in the setup cycle
   assign setupPhase  = psel & ~penable;
   assign accessPhase = psel & penable;
   assign addrHit     = (paddr == `PSM_CTRL_OFS) || (paddr == `PSM_STATUS_OFS) ||
                        (paddr == `PSM_EVENT_OFS);
   assign wrAccess    = accessPhase & pwrite & pstrb[0] & addrHit;
   assign pready      = 1'b1;
   assign pslverr     = accessPhase & ~addrHit;
   assign prdata      = prdata_reg;

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         prdata_reg <= 32'h0000_0000;
      end else if (setupPhase) begin
         case (paddr)
            `PSM_CTRL_OFS: begin
               prdata_reg <= {29'h000_0000, ctrl_reg};
            end
            `PSM_STATUS_OFS: begin
               prdata_reg <= {21'h00_0000, modeState_reg, addressStrap, strapDone_reg,
                              linkOkIn, fullDuplex_reg, speed100_reg};
            end
            `PSM_EVENT_OFS: begin
               prdata_reg <= {30'h0000_0000, event_reg};
            end
            default: begin
               prdata_reg <= 32'h0000_0000;
            end
         endcase
      end
   end

   // Only the low byte carries control bits; other lanes are ignored
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         ctrl_reg <= `PSM_CTRL_RST;
      end else if (wrAccess && (paddr == `PSM_CTRL_OFS)) begin
         ctrl_reg <= pwdata[`PSM_CTRL_W-1:0];
      end
   end

   // ****************************************************************
   // Sticky events
   // ****************************************************************
   // A new event in the clearing cycle survives the clear
   assign colLevel = collisionIn & ~fullDuplex_reg;
   assign eventSet = {colLevel & strapDone_reg, linkPrev_reg & ~linkOkIn & strapDone_reg};
   assign eventClr = (wrAccess && (paddr == `PSM_EVENT_OFS)) ?
                     pwdata[`PSM_EV_W-1:0] : `PSM_EV_RST;

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         event_reg <= `PSM_EV_RST;
      end else begin
         event_reg <= (event_reg & ~eventClr) | eventSet;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         linkPrev_reg <= 1'b0;
      end else begin
         linkPrev_reg <= linkOkIn;
      end
   end

   // ****************************************************************
   // Strap capture
   // ****************************************************************
   // Set on the first edge after release; the pin cells sample at that edge
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         strapDone_reg <= 1'b0;
      end else begin
         strapDone_reg <= 1'b1;
      end
   end

   // ****************************************************************
   // Media mode resolution
   // ****************************************************************
   always_comb begin
      modeState_next = modeState_reg;
      if (!strapDone_reg) begin
         modeState_next = psm_pkg::PSM_ST_STRAP;
      end else if (!anEnable) begin
         modeState_next = psm_pkg::PSM_ST_FORCED;
      end else if (anCompleteIn) begin
         modeState_next = psm_pkg::PSM_ST_AN_DONE;
      end else begin
         modeState_next = psm_pkg::PSM_ST_AN_WAIT;
      end
   end

   // With negotiation enabled, the line is held at 10 Mb/s half duplex until it completes
   always_comb begin
      speed100_next   = 1'b0;
      fullDuplex_next = 1'b0;
      case (modeState_next)
         psm_pkg::PSM_ST_FORCED: begin
            speed100_next   = forceSpeed100;
            fullDuplex_next = forceFullDuplex;
         end
         psm_pkg::PSM_ST_AN_DONE: begin
            speed100_next   = anSpeed100In;
            fullDuplex_next = anFullDuplexIn;
         end
         psm_pkg::PSM_ST_AN_WAIT: begin
            speed100_next   = 1'b0;
            fullDuplex_next = 1'b0;
         end
         default: begin
            speed100_next   = 1'b0;
            fullDuplex_next = 1'b0;
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         modeState_reg <= psm_pkg::PSM_ST_STRAP;
      end else begin
         modeState_reg <= modeState_next;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         speed100_reg   <= 1'b0;
         fullDuplex_reg <= 1'b0;
      end else begin
         speed100_reg   <= speed100_next;
         fullDuplex_reg <= fullDuplex_next;
      end
   end

   // Driver, receiver and speed lamp share one flop so they never disagree
   assign lineDriverPairMode100 = speed100_reg;
   assign receiverMode100       = speed100_reg;
   assign speedIndicator        = speed100_reg;

   // ****************************************************************
   // Indicator levels and dual-purpose pins
   // ****************************************************************
   always_comb begin
      levelNext                  = '0;
      levelNext[`PSM_PIN_DUPLEX] = fullDuplex_next;
      levelNext[`PSM_PIN_COL]    = colLevel;
      levelNext[`PSM_PIN_LINK]   = linkOkIn;
      levelNext[`PSM_PIN_TX]     = txActiveIn;
      levelNext[`PSM_PIN_RX]     = rxActiveIn;
   end

   genvar gi;
   generate
      for (gi = 0; gi < `PSM_PIN_COUNT; gi = gi + 1) begin : g_pin
         psm_pin_cell u_cell (
            .sys_clk   (sys_clk),
            .rstn      (rstn),
            .strapDone (strapDone_reg),
            .levelNext (levelNext[gi]),
            .pinIn     (dualPinIn[gi]),
            .strapBit  (addressStrap[gi]),
            .pinOut    (dualPinOut[gi]),
            .pinOeN    (dualPinOeN[gi])
         );
      end
   endgenerate

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rstn);

   sequence releaseSeq;
      !strapDone_reg ##1 strapDone_reg;
   endsequence

   sequence anDoneSeq;
      strapDone_reg && anEnable && anCompleteIn;
   endsequence

   sequence forcedSeq;
      strapDone_reg && !anEnable;
   endsequence

   speed_forced_a: assert property (
      (strapDone_reg && !anEnable && forceSpeed100) |=> speedIndicator)
      else $error("speed indicator low while forced to 100");

   speed_an_wait_a: assert property (
      (strapDone_reg && anEnable && !anCompleteIn) |=> !speedIndicator)
      else $error("speed indicator high before negotiation done");

   tx_follow_a: assert property (
      strapDone_reg |=> (dualPinOut[`PSM_PIN_TX] == $past(txActiveIn)))
      else $error("transmit indicator does not follow activity");

   rx_on_off_a: assert property (
      (strapDone_reg && rxActiveIn ##1 !rxActiveIn) |->
      dualPinOut[`PSM_PIN_RX] ##1 !dualPinOut[`PSM_PIN_RX])
      else $error("receive indicator wrong around end of activity");

   col_full_a: assert property (
      fullDuplex_reg |=> !dualPinOut[`PSM_PIN_COL])
      else $error("collision indicator lit in full duplex");

   col_half_a: assert property (
      (strapDone_reg && collisionIn && !fullDuplex_reg) |=> dualPinOut[`PSM_PIN_COL])
      else $error("collision in half duplex not shown");

   link_follow_a: assert property (
      strapDone_reg |=> (dualPinOut[`PSM_PIN_LINK] == $past(linkOkIn)))
      else $error("good link indicator does not follow link");

   duplex_an_a: assert property (
      anDoneSeq |=> (dualPinOut[`PSM_PIN_DUPLEX] == $past(anFullDuplexIn)))
      else $error("duplex indicator differs from negotiated duplex");

   driver_an_a: assert property (
      anDoneSeq |=> (lineDriverPairMode100 == $past(anSpeed100In)))
      else $error("line driver speed differs from negotiated speed");

   rcv_forced_a: assert property (
      forcedSeq |=> (receiverMode100 == $past(forceSpeed100)))
      else $error("receiver speed differs from forced speed");

   strap_capture_a: assert property (
      releaseSeq |-> (addressStrap == $past(dualPinIn)))
      else $error("strap value not captured at release");

   oe_before_a: assert property (
      !strapDone_reg |-> (&dualPinOeN && (dualPinOut == '0)))
      else $error("dual pin driven before strap capture");

   oe_after_a: assert property (
      releaseSeq |-> ((dualPinOeN == '0) ##1 (dualPinOeN == '0)))
      else $error("dual pin not driven after strap capture");

   link_lost_a: assert property (
      (strapDone_reg && linkPrev_reg && !linkOkIn) |=> event_reg[`PSM_EV_LINKLOST_BIT])
      else $error("link loss event not latched");

   apb_error_a: assert property (
      (accessPhase && !addrHit) |-> (pslverr && pready))
      else $error("unmapped access not flagged");

endmodule // psm_status_top

// [psm_defs.svh]
// Offsets, field positions, reset values and pin indices of the status block
`ifndef PSM_DEFS_SVH
`define PSM_DEFS_SVH

// ****************************************************************
// APB register map
// ****************************************************************
`define PSM_ADDR_W           12
`define PSM_CTRL_OFS         12'h000
`define PSM_STATUS_OFS       12'h004
`define PSM_EVENT_OFS        12'h008

// ****************************************************************
// Control register fields
// ****************************************************************
`define PSM_CTRL_AN_EN_BIT   0
`define PSM_CTRL_SPD100_BIT  1
`define PSM_CTRL_FULLDUP_BIT 2
`define PSM_CTRL_W           3
`define PSM_CTRL_RST         3'h3

// ****************************************************************
// Status register fields
// ****************************************************************
`define PSM_STAT_SPD100_BIT  0
`define PSM_STAT_FULLDUP_BIT 1
`define PSM_STAT_LINK_BIT    2
`define PSM_STAT_STRAP_BIT   3
`define PSM_STAT_ADDR_LSB    4
`define PSM_STAT_MODE_LSB    9

// ****************************************************************
// Event register fields, write one to clear
// ****************************************************************
`define PSM_EV_LINKLOST_BIT  0
`define PSM_EV_COLSEEN_BIT   1
`define PSM_EV_W             2
`define PSM_EV_RST           2'h0

// ****************************************************************
// Dual-purpose pin indices
// ****************************************************************
`define PSM_PIN_COUNT        5
`define PSM_PIN_DUPLEX       0
`define PSM_PIN_COL          1
`define PSM_PIN_LINK         2
`define PSM_PIN_TX           3
`define PSM_PIN_RX           4

`endif

// [psm_pkg.sv]
// Types shared by the status block
package psm_pkg;

   // ****************************************************************
   // Media mode resolution states
   // ****************************************************************
   typedef enum logic [1:0] {
      PSM_ST_STRAP,
      PSM_ST_FORCED,
      PSM_ST_AN_WAIT,
      PSM_ST_AN_DONE
   } psm_mode_t;

endpackage

// [psm_pin_cell.sv]
// One dual-purpose pin: strap capture at reset release, then indicator drive
`timescale 1ns/1ns

module psm_pin_cell (
   input  wire logic sys_clk,
   input  wire logic rstn,
   input  wire logic strapDone,
   input  wire logic levelNext,
   input  wire logic pinIn,
   output logic      strapBit,
   output logic      pinOut,
   output logic      pinOeN
);

   logic strapBit_reg;
   logic pinOut_reg;
   logic pinOeN_reg;

   // Sampled on the first edge after release, while nobody drives the pin
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         strapBit_reg <= 1'b0;
      end else if (!strapDone) begin
         strapBit_reg <= pinIn;
      end
   end

   // Driver stays off through reset so the strap resistor sets the level
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         pinOeN_reg <= 1'b1;
      end else if (!strapDone) begin
         pinOeN_reg <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         pinOut_reg <= 1'b0;
      end else begin
         pinOut_reg <= strapDone & levelNext;
      end
   end

   assign strapBit = strapBit_reg;
   assign pinOut   = pinOut_reg;
   assign pinOeN   = pinOeN_reg;

endmodule // psm_pin_cell

// [psm_led_model.sv]
// Far-side model: strap resistors, indicator lamps and reference clock
`timescale 1ns/1ns

module psm_led_model #(
   parameter logic [4:0] STRAP_VAL = 5'h15
) (
   input  wire logic [4:0] pinDrive,
   input  wire logic [4:0] pinOeN,
   output logic      [4:0] pinLevel,
   output logic      [4:0] lampOn,
   output logic            refClk
);
   // ******************************
   // Pin wires
   // ******************************
   // Undriven pins fall to their strap resistor, never keep the last driven level
   always_comb begin
      for (int i = 0; i < 5; i++) begin
         pinLevel[i] = pinOeN[i] ? STRAP_VAL[i] : pinDrive[i];
      end
   end

   assign lampOn = pinLevel & ~pinOeN;

   // Reference source of the system; the block itself runs on sys_clk only
   initial refClk = 1'b0;
   always #20 refClk = ~refClk;
endmodule // psm_led_model

// [testbench.sv]
// Self-checking bench for status indicators, strap capture and media mode
`timescale 1ns/1ns
`include "psm_defs.svh"

module testbench;
   localparam logic [4:0] STRAP = 5'h15;
   logic        sys_clk;
   logic        rstn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [3:0]  pstrb;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        linkOkIn;
   logic        txActiveIn;
   logic        rxActiveIn;
   logic        collisionIn;
   logic        anCompleteIn;
   logic        anSpeed100In;
   logic        anFullDuplexIn;
   logic [4:0]  dualPinIn;
   logic [4:0]  dualPinOut;
   logic [4:0]  dualPinOeN;
   logic [4:0]  addressStrap;
   logic        speedIndicator;
   logic        lineDriverPairMode100;
   logic        receiverMode100;
   logic [31:0] rdVal;
   logic        rdErr;
   int          nMismatch = 0;
   int          compares = 0;

   psm_status_top psm_status_top_inst (
      .sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .linkOkIn(linkOkIn), .txActiveIn(txActiveIn),
      .rxActiveIn(rxActiveIn), .collisionIn(collisionIn), .anCompleteIn(anCompleteIn),
      .anSpeed100In(anSpeed100In), .anFullDuplexIn(anFullDuplexIn),
      .dualPinIn(dualPinIn), .dualPinOut(dualPinOut), .dualPinOeN(dualPinOeN),
      .addressStrap(addressStrap), .speedIndicator(speedIndicator),
      .lineDriverPairMode100(lineDriverPairMode100), .receiverMode100(receiverMode100));

   psm_led_model #(.STRAP_VAL(STRAP)) psm_led_model_inst (
      .pinDrive(dualPinOut), .pinOeN(dualPinOeN), .pinLevel(dualPinIn),
      .lampOn(), .refClk());

   always #4 sys_clk = ~sys_clk;

   // ******************************
   // Shared tasks
   // ******************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         nMismatch++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic results();
      $display("Counts: compares=%0d mismatches=%0d", compares, nMismatch);
      if (nMismatch == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   // Request held until pready is seen high at a rising edge
   task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data,
                      output logic [31:0] rd, output logic err);
      int n = 0;
      @(posedge sys_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= addr;
      pwdata  <= data;
      pstrb   <= 4'hf;
      @(posedge sys_clk);
      penable <= 1'b1;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         nMismatch++;
      end
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // ******************************
   // Scenarios
   // ******************************
   task automatic doReset();
      @(posedge sys_clk);
      rstn <= 1'b0;
      settle(10);
      check(dualPinOeN, 5'h1f);
      check(dualPinOut, 5'h00);
      @(posedge sys_clk);
      rstn <= 1'b1;
      settle(1);
      check(addressStrap, STRAP);
      check(dualPinOeN, 5'h00);
      check(dualPinOut, 5'h00);
      apb(1'b0, `PSM_CTRL_OFS, 32'h0, rdVal, rdErr);
      check(rdVal, 32'h0000_0003);
      apb(1'b0, `PSM_STATUS_OFS, 32'h0, rdVal, rdErr);
      check(rdVal & 32'h0000_01f8, {23'h0, STRAP, 4'h8});
   endtask

   task automatic testForced();
      logic [1:0] m;
      for (int i = 0; i < 4; i++) begin
         m = i[1:0];
         apb(1'b1, `PSM_CTRL_OFS, {29'h0, m, 1'b0}, rdVal, rdErr);
         settle(3);
         check(speedIndicator, m[0]);
         check(lineDriverPairMode100, m[0]);
         check(receiverMode100, m[0]);
         check(dualPinOut[`PSM_PIN_DUPLEX], m[1]);
         apb(1'b0, `PSM_STATUS_OFS, 32'h0, rdVal, rdErr);
         check(rdVal[1:0], m);
      end
   endtask

   task automatic testActivity();
      logic [2:0] pat [3] = '{3'b101, 3'b010, 3'b000};
      for (int i = 0; i < 3; i++) begin
         @(posedge sys_clk);
         {rxActiveIn, txActiveIn, linkOkIn} <= pat[i];
         settle(1);
         check(dualPinOut[`PSM_PIN_LINK], pat[i][0]);
         check(dualPinOut[`PSM_PIN_TX], pat[i][1]);
         check(dualPinOut[`PSM_PIN_RX], pat[i][2]);
      end
   endtask

   task automatic testCollision();
      apb(1'b1, `PSM_CTRL_OFS, 32'h0000_0002, rdVal, rdErr);
      settle(3);
      check(dualPinOut[`PSM_PIN_COL], 1'b0);
      @(posedge sys_clk);
      collisionIn <= 1'b1;
      settle(1);
      check(dualPinOut[`PSM_PIN_COL], 1'b1);
      apb(1'b1, `PSM_CTRL_OFS, 32'h0000_0006, rdVal, rdErr);
      settle(3);
      check(dualPinOut[`PSM_PIN_COL], 1'b0);
      check(dualPinOut[`PSM_PIN_DUPLEX], 1'b1);
      @(posedge sys_clk);
      collisionIn <= 1'b0;
   endtask

   // Force bits set while negotiating, so they must be ignored both before and after it completes
   task automatic testAutoneg();
      @(posedge sys_clk);
      anSpeed100In   <= 1'b1;
      anFullDuplexIn <= 1'b1;
      apb(1'b1, `PSM_CTRL_OFS, 32'h0000_0007, rdVal, rdErr);
      settle(3);
      check(speedIndicator, 1'b0);
      check(dualPinOut[`PSM_PIN_DUPLEX], 1'b0);
      @(posedge sys_clk);
      anCompleteIn <= 1'b1;
      settle(3);
      check(lineDriverPairMode100, 1'b1);
      check(receiverMode100, 1'b1);
      check(dualPinOut[`PSM_PIN_DUPLEX], 1'b1);
      @(posedge sys_clk);
      anSpeed100In <= 1'b0;
      settle(3);
      check(speedIndicator, 1'b0);
      check(lineDriverPairMode100, 1'b0);
   endtask

   // Link fell in the activity scenario, collision was seen in half duplex
   task automatic testEvents();
      apb(1'b0, `PSM_EVENT_OFS, 32'h0, rdVal, rdErr);
      check(rdVal, 32'h0000_0003);
      apb(1'b1, `PSM_EVENT_OFS, 32'h0000_0001, rdVal, rdErr);
      apb(1'b0, `PSM_EVENT_OFS, 32'h0, rdVal, rdErr);
      check(rdVal, 32'h0000_0002);
      apb(1'b1, `PSM_EVENT_OFS, 32'h0000_0002, rdVal, rdErr);
      apb(1'b0, `PSM_EVENT_OFS, 32'h0, rdVal, rdErr);
      check(rdVal, 32'h0000_0000);
   endtask

   task automatic testUnmapped();
      apb(1'b0, 12'h00c, 32'h0, rdVal, rdErr);
      check(rdErr, 1'b1);
      check(rdVal, 32'h0);
      apb(1'b0, `PSM_CTRL_OFS, 32'h0, rdVal, rdErr);
      check(rdErr, 1'b0);
   endtask

   // ******************************
   // Main sequence and watchdog
   // ******************************
   initial begin
      sys_clk        = 1'b0;
      rstn           = 1'b0;
      psel           = 1'b0;
      penable        = 1'b0;
      pwrite         = 1'b0;
      paddr          = 12'h000;
      pwdata         = 32'h0;
      pstrb          = 4'h0;
      linkOkIn       = 1'b0;
      txActiveIn     = 1'b0;
      rxActiveIn     = 1'b0;
      collisionIn    = 1'b0;
      anCompleteIn   = 1'b0;
      anSpeed100In   = 1'b0;
      anFullDuplexIn = 1'b0;
      doReset();
      testForced();
      testActivity();
      apb(1'b1, `PSM_CTRL_OFS, 32'h0, rdVal, rdErr);
      settle(3);
      testActivity();
      testCollision();
      testEvents();
      testAutoneg();
      testUnmapped();
      doReset();
      results();
   end

   initial begin
      repeat (5000) @(posedge sys_clk);
      nMismatch++;
      results();
   end
endmodule // testbench
